// *** core/pwm_act_map.vh ***
// Register offsets, field positions and reset values of the output action block
// Assumes a 12-bit register offset and 32-bit data words
`ifndef PWM_ACT_MAP_VH
`define PWM_ACT_MAP_VH

// Register offsets
`define OFS_MASTER_CTL 12'h000
`define OFS_OUT_STATE 12'h008
`define OFS_GEN0_CTL 12'h040
`define OFS_GEN0_ACT_A 12'h060
`define OFS_GEN0_ACT_B 12'h064
`define OFS_GEN1_CTL 12'h080
`define OFS_GEN1_ACT_A 12'h0a0
`define OFS_GEN1_ACT_B 12'h0a4

// Action register fields
`define ACT_W 12
`define ACT_ZERO_LSB 0
`define ACT_LOAD_LSB 2
`define ACT_CMPA_UP_LSB 4
`define ACT_CMPA_DN_LSB 6
`define ACT_CMPB_UP_LSB 8
`define ACT_CMPB_DN_LSB 10

// Action codes
`define ACT_KEEP 2'h0
`define ACT_TOGGLE 2'h1
`define ACT_LOW 2'h2
`define ACT_HIGH 2'h3

// Generator control fields
`define CTL_W 3
`define CTL_MODE_BIT 0
`define CTL_A_UPD_BIT 1
`define CTL_B_UPD_BIT 2

// Master control fields
`define MCTL_SYNC_W 2

// Reset values
`define ACT_RST 12'h000
`define CTL_RST 3'h0
`define MCTL_RST 2'h0

`endif

// *** core/ahb_reg_slave.v ***
// AHB-Lite slave front end: single-word register access
// Assumes one slave per bus, hready fed back from hreadyout
`timescale 1ns/10ps
`default_nettype none
module ahb_reg_slave (
    input wire hclk_i,
    input wire hresetn_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire hready_i,
    input wire [31:0] hwdata_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output reg [31:0] hrdata_o,
    output wire reg_wr_o,
    output wire [11:0] reg_addr_o,
    output wire [31:0] reg_wdata_o,
    input wire [31:0] reg_rdata_i
);
    reg [11:0] addr_r;
    reg wr_pend_r;
    reg rd_wait_r;
    wire take;

    // Address phase accepted
    assign take = hsel_i & htrans_i[1] & hready_i;
    // Reads take one wait state to register read data
    assign hreadyout_o = ~rd_wait_r;
    assign hresp_o = 1'b0;
    assign reg_wr_o = wr_pend_r;
    assign reg_addr_o = addr_r;
    assign reg_wdata_o = hwdata_i;

    always @(posedge hclk_i or negedge hresetn_i) begin
        if (!hresetn_i) begin
            addr_r <= 12'h000;
            wr_pend_r <= 1'b0;
            rd_wait_r <= 1'b0;
            hrdata_o <= 32'h0000_0000;
        end else begin
            if (take) begin
                addr_r <= {haddr_i[11:2], 2'b00};
            end
            wr_pend_r <= take & hwrite_i & (hsize_i == 3'h2);
            rd_wait_r <= take & ~hwrite_i;
            if (rd_wait_r) begin
                hrdata_o <= reg_rdata_i;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/pwm_action_unit.v ***
// One output channel: pending and active action sets, event priority, output flop
// Assumes event strobes are one-cycle pulses on the same clock
`timescale 1ns/10ps
`default_nettype none
`include "pwm_act_map.vh"
module pwm_action_unit #(
    parameter CMP_B_WINS = 0
) (
    input wire clk_i,
    input wire resetn_i,
    input wire wr_i,
    input wire [`ACT_W-1:0] wdata_i,
    input wire sync_mode_i,
    input wire sync_req_i,
    input wire ev_zero_i,
    input wire ev_load_i,
    input wire ev_a_up_i,
    input wire ev_a_dn_i,
    input wire ev_b_up_i,
    input wire ev_b_dn_i,
    output wire [`ACT_W-1:0] cfg_o,
    output wire out_o
);
    reg [`ACT_W-1:0] pend_r;
    reg pend_valid_r;
    reg [`ACT_W-1:0] act_r;
    reg out_r;
    reg out_nxt;
    wire apply;
    wire [`ACT_W-1:0] use_cfg;
    wire ev_a;
    wire ev_b;
    wire [1:0] code_a;
    wire [1:0] code_b;

    function out_step;
        input cur;
        input [1:0] code;
        begin
            case (code)
                `ACT_KEEP: out_step = cur;
                `ACT_TOGGLE: out_step = ~cur;
                `ACT_LOW: out_step = 1'b0;
                `ACT_HIGH: out_step = 1'b1;
                default: out_step = cur;
            endcase
        end
    endfunction

    // New set loads only at counter zero
    assign apply = ev_zero_i & pend_valid_r & (~sync_mode_i | sync_req_i);
    assign use_cfg = apply ? pend_r : act_r;
    assign cfg_o = pend_r;
    assign out_o = out_r;

    assign ev_a = ev_a_up_i | ev_a_dn_i;
    assign ev_b = ev_b_up_i | ev_b_dn_i;
    assign code_a = ev_a_up_i ? use_cfg[`ACT_CMPA_UP_LSB +: 2] : use_cfg[`ACT_CMPA_DN_LSB +: 2];
    assign code_b = ev_b_up_i ? use_cfg[`ACT_CMPB_UP_LSB +: 2] : use_cfg[`ACT_CMPB_DN_LSB +: 2];

    always @* begin
        out_nxt = out_r;
        if (ev_zero_i | ev_load_i) begin
            // Counter events override compares
            if (ev_zero_i) begin
                out_nxt = out_step(out_nxt, use_cfg[`ACT_ZERO_LSB +: 2]);
            end
            if (ev_load_i) begin
                out_nxt = out_step(out_nxt, use_cfg[`ACT_LOAD_LSB +: 2]);
            end
        end else if (ev_a & ev_b) begin
            if (CMP_B_WINS != 0) begin
                out_nxt = out_step(out_r, code_b);
            end else begin
                out_nxt = out_step(out_r, code_a);
            end
        end else if (ev_a) begin
            out_nxt = out_step(out_r, code_a);
        end else if (ev_b) begin
            out_nxt = out_step(out_r, code_b);
        end
    end

    always @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pend_r <= `ACT_RST;
            pend_valid_r <= 1'b0;
            act_r <= `ACT_RST;
            out_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            if (apply) begin
                act_r <= pend_r;
            end
            // Newest write replaces any pending set
            if (wr_i) begin
                pend_r <= wdata_i;
                pend_valid_r <= 1'b1;
            end else if (apply) begin
                pend_valid_r <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/pwm_output_action_logic.v ***
// Output action logic for two generators, A and B outputs each, on AHB-Lite
// Assumes counter and comparator event pulses come from logic on CLK_I
//
// Behaviour
// - Action codes: 0 keep, 1 toggle, 2 drive low, 3 drive high.
// - Bits 9:8 act on compare B while counting up, up/down mode only.
// - Bits 7:6 act on compare A while counting down.
// - Bits 5:4 act on compare A while counting up, up/down mode only.
// - Bits 3:2 act when the counter equals the load value.
// - Bits 1:0 act when the counter equals zero.
// - Down mode gives four events; up/down mode gives all six.
// - Zero or load action overrides any coinciding compare action.
// - On the B output, compare B beats a coinciding compare A.
// - Each generator has its own B action register driving its own B output.
// - Immediate update mode applies a newly written set at the next zero.
// - Synchronous mode applies it at the first zero after a sync request.
// - A rewrite before the update discards the earlier pending set.
// - On the A output, compare A beats a coinciding compare B.
// - Bits 11:10 act on compare B while counting down.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "pwm_act_map.vh"
module pwm_output_action_logic (
    input wire CLK_I,
    input wire RESETN_I,
    input wire HSEL_I,
    input wire [31:0] HADDR_I,
    input wire [1:0] HTRANS_I,
    input wire HWRITE_I,
    input wire [2:0] HSIZE_I,
    input wire [2:0] HBURST_I,
    input wire [3:0] HPROT_I,
    input wire HREADY_I,
    input wire [31:0] HWDATA_I,
    output wire HREADYOUT_O,
    output wire HRESP_O,
    output wire [31:0] HRDATA_O,
    input wire [1:0] CNT_ZERO_I,
    input wire [1:0] CNT_LOAD_I,
    input wire [1:0] CMP_A_I,
    input wire [1:0] CMP_B_I,
    input wire [1:0] CNT_UP_I,
    output wire GEN0_OUTPUT_A_O,
    output wire GEN0_OUTPUT_B_O,
    output wire GEN1_OUTPUT_A_O,
    output wire GEN1_OUTPUT_B_O
);
    wire reg_wr;
    wire [11:0] reg_addr;
    wire [31:0] reg_wdata;
    reg [31:0] reg_rdata;

    reg [`CTL_W-1:0] gen0_ctl_r;
    reg [`CTL_W-1:0] gen1_ctl_r;
    reg [`MCTL_SYNC_W-1:0] sync_req_r;
    reg [`MCTL_SYNC_W-1:0] sync_req_nxt;

    wire wr_gen0_ctl;
    wire wr_gen1_ctl;
    wire wr_master;
    wire wr_gen0_a;
    wire wr_gen0_b;
    wire wr_gen1_a;
    wire wr_gen1_b;

    wire [`ACT_W-1:0] gen0_a_cfg;
    wire [`ACT_W-1:0] gen0_b_cfg;
    wire [`ACT_W-1:0] gen1_a_cfg;
    wire [`ACT_W-1:0] gen1_b_cfg;

    wire [1:0] up_mode;
    wire [1:0] counting_up;
    wire [1:0] ev_a_up;
    wire [1:0] ev_a_dn;
    wire [1:0] ev_b_up;
    wire [1:0] ev_b_dn;

    wire gen0_out_a;
    wire gen0_out_b;
    wire gen1_out_a;
    wire gen1_out_b;

    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    ahb_reg_slave u_bus (
        .hclk_i(CLK_I),
        .hresetn_i(RESETN_I),
        .hsel_i(HSEL_I),
        .haddr_i(HADDR_I),
        .htrans_i(HTRANS_I),
        .hwrite_i(HWRITE_I),
        .hsize_i(HSIZE_I),
        .hready_i(HREADY_I),
        .hwdata_i(HWDATA_I),
        .hreadyout_o(HREADYOUT_O),
        .hresp_o(HRESP_O),
        .hrdata_o(HRDATA_O),
        .reg_wr_o(reg_wr),
        .reg_addr_o(reg_addr),
        .reg_wdata_o(reg_wdata),
        .reg_rdata_i(reg_rdata)
    );

    // Write decode
    assign wr_master = reg_wr & hit(reg_addr, `OFS_MASTER_CTL);
    assign wr_gen0_ctl = reg_wr & hit(reg_addr, `OFS_GEN0_CTL);
    assign wr_gen1_ctl = reg_wr & hit(reg_addr, `OFS_GEN1_CTL);
    assign wr_gen0_a = reg_wr & hit(reg_addr, `OFS_GEN0_ACT_A);
    assign wr_gen0_b = reg_wr & hit(reg_addr, `OFS_GEN0_ACT_B);
    assign wr_gen1_a = reg_wr & hit(reg_addr, `OFS_GEN1_ACT_A);
    assign wr_gen1_b = reg_wr & hit(reg_addr, `OFS_GEN1_ACT_B);

    // Read mux, unmapped offsets read zero
    always @* begin
        reg_rdata = 32'h0000_0000;
        case (reg_addr)
            `OFS_MASTER_CTL: reg_rdata = {30'h0000_0000, sync_req_r};
            `OFS_OUT_STATE: reg_rdata = {28'h000_0000, gen1_out_b, gen1_out_a,
                gen0_out_b, gen0_out_a};
            `OFS_GEN0_CTL: reg_rdata = {29'h0000_0000, gen0_ctl_r};
            `OFS_GEN1_CTL: reg_rdata = {29'h0000_0000, gen1_ctl_r};
            `OFS_GEN0_ACT_A: reg_rdata = {20'h0_0000, gen0_a_cfg};
            `OFS_GEN0_ACT_B: reg_rdata = {20'h0_0000, gen0_b_cfg};
            `OFS_GEN1_ACT_A: reg_rdata = {20'h0_0000, gen1_a_cfg};
            `OFS_GEN1_ACT_B: reg_rdata = {20'h0_0000, gen1_b_cfg};
            default: reg_rdata = 32'h0000_0000;
        endcase
    end

    // Sync request held per generator until its next zero; a new request wins
    always @* begin
        sync_req_nxt = sync_req_r & ~CNT_ZERO_I;
        if (wr_master) begin
            sync_req_nxt = sync_req_nxt | reg_wdata[`MCTL_SYNC_W-1:0];
        end
    end

    always @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            gen0_ctl_r <= `CTL_RST;
            gen1_ctl_r <= `CTL_RST;
            sync_req_r <= `MCTL_RST;
        end else begin
            sync_req_r <= sync_req_nxt;
            if (wr_gen0_ctl) begin
                gen0_ctl_r <= reg_wdata[`CTL_W-1:0];
            end
            if (wr_gen1_ctl) begin
                gen1_ctl_r <= reg_wdata[`CTL_W-1:0];
            end
        end
    end

    // Event qualification: up events exist only in up/down mode
    assign up_mode = {gen1_ctl_r[`CTL_MODE_BIT], gen0_ctl_r[`CTL_MODE_BIT]};
    assign counting_up = up_mode & CNT_UP_I;
    assign ev_a_up = CMP_A_I & counting_up;
    assign ev_a_dn = CMP_A_I & ~counting_up;
    assign ev_b_up = CMP_B_I & counting_up;
    assign ev_b_dn = CMP_B_I & ~counting_up;

    pwm_action_unit #(
        .CMP_B_WINS(0)
    ) u_gen0_a (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .wr_i(wr_gen0_a),
        .wdata_i(reg_wdata[`ACT_W-1:0]),
        .sync_mode_i(gen0_ctl_r[`CTL_A_UPD_BIT]),
        .sync_req_i(sync_req_r[0]),
        .ev_zero_i(CNT_ZERO_I[0]),
        .ev_load_i(CNT_LOAD_I[0]),
        .ev_a_up_i(ev_a_up[0]),
        .ev_a_dn_i(ev_a_dn[0]),
        .ev_b_up_i(ev_b_up[0]),
        .ev_b_dn_i(ev_b_dn[0]),
        .cfg_o(gen0_a_cfg),
        .out_o(gen0_out_a)
    );

    pwm_action_unit #(
        .CMP_B_WINS(1)
    ) u_gen0_b (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .wr_i(wr_gen0_b),
        .wdata_i(reg_wdata[`ACT_W-1:0]),
        .sync_mode_i(gen0_ctl_r[`CTL_B_UPD_BIT]),
        .sync_req_i(sync_req_r[0]),
        .ev_zero_i(CNT_ZERO_I[0]),
        .ev_load_i(CNT_LOAD_I[0]),
        .ev_a_up_i(ev_a_up[0]),
        .ev_a_dn_i(ev_a_dn[0]),
        .ev_b_up_i(ev_b_up[0]),
        .ev_b_dn_i(ev_b_dn[0]),
        .cfg_o(gen0_b_cfg),
        .out_o(gen0_out_b)
    );

    pwm_action_unit #(
        .CMP_B_WINS(0)
    ) u_gen1_a (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .wr_i(wr_gen1_a),
        .wdata_i(reg_wdata[`ACT_W-1:0]),
        .sync_mode_i(gen1_ctl_r[`CTL_A_UPD_BIT]),
        .sync_req_i(sync_req_r[1]),
        .ev_zero_i(CNT_ZERO_I[1]),
        .ev_load_i(CNT_LOAD_I[1]),
        .ev_a_up_i(ev_a_up[1]),
        .ev_a_dn_i(ev_a_dn[1]),
        .ev_b_up_i(ev_b_up[1]),
        .ev_b_dn_i(ev_b_dn[1]),
        .cfg_o(gen1_a_cfg),
        .out_o(gen1_out_a)
    );

    pwm_action_unit #(
        .CMP_B_WINS(1)
    ) u_gen1_b (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .wr_i(wr_gen1_b),
        .wdata_i(reg_wdata[`ACT_W-1:0]),
        .sync_mode_i(gen1_ctl_r[`CTL_B_UPD_BIT]),
        .sync_req_i(sync_req_r[1]),
        .ev_zero_i(CNT_ZERO_I[1]),
        .ev_load_i(CNT_LOAD_I[1]),
        .ev_a_up_i(ev_a_up[1]),
        .ev_a_dn_i(ev_a_dn[1]),
        .ev_b_up_i(ev_b_up[1]),
        .ev_b_dn_i(ev_b_dn[1]),
        .cfg_o(gen1_b_cfg),
        .out_o(gen1_out_b)
    );

    // Independent outputs per generator
    assign GEN0_OUTPUT_A_O = gen0_out_a;
    assign GEN0_OUTPUT_B_O = gen0_out_b;
    assign GEN1_OUTPUT_A_O = gen1_out_a;
    assign GEN1_OUTPUT_B_O = gen1_out_b;
endmodule
`default_nettype wire

// *** tb/pwm_action_checker_assertions.sv ***
// Port checker for the output action block
// Assumes the bind below onto the top module, one clock
`timescale 1ns/10ps
`default_nettype none
module pwm_action_checker (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic HSEL_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic HREADY_I,
    input wire logic HREADYOUT_O,
    input wire logic HRESP_O,
    input wire logic [31:0] HRDATA_O,
    input wire logic [1:0] CNT_ZERO_I,
    input wire logic [1:0] CNT_LOAD_I,
    input wire logic [1:0] CMP_A_I,
    input wire logic [1:0] CMP_B_I,
    input wire logic GEN0_OUTPUT_A_O,
    input wire logic GEN0_OUTPUT_B_O,
    input wire logic GEN1_OUTPUT_A_O,
    input wire logic GEN1_OUTPUT_B_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    wire logic take = HSEL_I & HTRANS_I[1] & HREADY_I;
    wire logic [1:0] quiet = ~(CNT_ZERO_I | CNT_LOAD_I | CMP_A_I | CMP_B_I);
    // Read data phase: one wait, then done
    sequence rd_wait;
        !HREADYOUT_O ##1 HREADYOUT_O;
    endsequence
    a_g0a_hold: assert property (quiet[0] |=> $stable(GEN0_OUTPUT_A_O)) else $error("g0 a moved");
    a_g0b_hold: assert property (quiet[0] |=> $stable(GEN0_OUTPUT_B_O)) else $error("g0 b moved");
    a_g1a_hold: assert property (quiet[1] |=> $stable(GEN1_OUTPUT_A_O)) else $error("g1 a moved");
    a_g1b_hold: assert property (quiet[1] |=> $stable(GEN1_OUTPUT_B_O)) else $error("g1 b moved");
    a_rd_wait: assert property (take && !HWRITE_I |=> rd_wait) else $error("read wait wrong");
    a_wr_nowait: assert property (take && HWRITE_I |=> HREADYOUT_O) else $error("write stalled");
    a_resp_okay: assert property (HRESP_O == 1'b0) else $error("response not okay");
    a_data_hold: assert property (HREADYOUT_O |=> $stable(HRDATA_O)) else $error("read data moved");
    a_reset_clear: assert property ($rose(RESETN_I) |-> !(GEN0_OUTPUT_A_O | GEN0_OUTPUT_B_O
        | GEN1_OUTPUT_A_O | GEN1_OUTPUT_B_O)) else $error("outputs not clear");
endmodule
bind pwm_output_action_logic pwm_action_checker pwm_action_checker_i (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
    .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HREADYOUT_O(HREADYOUT_O),
    .HRESP_O(HRESP_O), .HRDATA_O(HRDATA_O), .CNT_ZERO_I(CNT_ZERO_I),
    .CNT_LOAD_I(CNT_LOAD_I), .CMP_A_I(CMP_A_I), .CMP_B_I(CMP_B_I),
    .GEN0_OUTPUT_A_O(GEN0_OUTPUT_A_O), .GEN0_OUTPUT_B_O(GEN0_OUTPUT_B_O),
    .GEN1_OUTPUT_A_O(GEN1_OUTPUT_A_O), .GEN1_OUTPUT_B_O(GEN1_OUTPUT_B_O));
`default_nettype wire

// *** tb/pwm_event_source.sv ***
// Counter and comparator event source for both generators
// Assumes requests change just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module pwm_event_source (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic gen_i,
    input wire logic [4:0] ev_i,
    output logic [1:0] zero_o,
    output logic [1:0] load_o,
    output logic [1:0] cmp_a_o,
    output logic [1:0] cmp_b_o,
    output logic [1:0] up_o
);
    wire logic [1:0] sel = req_i ? {gen_i, ~gen_i} : 2'h0;
    initial begin
        up_o = 2'h0;
    end
    // One-cycle pulses, direction kept as a level
    always @(posedge clk_i) begin
        zero_o <= sel & {2{ev_i[0]}};
        load_o <= sel & {2{ev_i[1]}};
        cmp_a_o <= sel & {2{ev_i[2]}};
        cmp_b_o <= sel & {2{ev_i[3]}};
        if (req_i) begin
            up_o[gen_i] <= ev_i[4];
        end
    end
endmodule
`default_nettype wire

// *** tb/pwm_output_action_logic_bench.sv ***
// Self-checking bench for the output action block
// Assumes the checker file is compiled with it for its bind
`timescale 1ns/10ps
`default_nettype none
`include "pwm_act_map.vh"
module pwm_output_action_logic_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic req = 1'b0;
    logic gen = 1'b0;
    logic [4:0] ev = 5'h0;
    logic dp_rd = 1'b0;
    wire logic hready;
    wire logic [31:0] hrdata;
    wire logic [1:0] zero, load, ca, cb, up;
    wire logic [3:0] outs;
    logic [11:0] act [4] = '{default: 12'h0};
    logic [11:0] pend [4] = '{default: 12'h0};
    logic [2:0] ctl [2] = '{default: 3'h0};
    logic [1:0] sreq = 2'h0;
    logic [3:0] oe = 4'h0;
    logic [3:0] e_out;
    logic [3:0] out_q[$];
    logic [31:0] rd_q[$];
    logic [11:0] regs [9] = '{`OFS_MASTER_CTL, `OFS_OUT_STATE, `OFS_GEN0_CTL, `OFS_GEN0_ACT_A,
        `OFS_GEN0_ACT_B, `OFS_GEN1_CTL, `OFS_GEN1_ACT_A, `OFS_GEN1_ACT_B, 12'h010};
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 34690;

    always #20 clk = ~clk;

    pwm_output_action_logic pwm_output_action_logic_i (
        .CLK_I(clk), .RESETN_I(rstn), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
        .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HBURST_I(3'h0), .HPROT_I(4'h0),
        .HREADY_I(hready), .HWDATA_I(hwdata), .HREADYOUT_O(hready), .HRESP_O(),
        .HRDATA_O(hrdata), .CNT_ZERO_I(zero), .CNT_LOAD_I(load), .CMP_A_I(ca),
        .CMP_B_I(cb), .CNT_UP_I(up), .GEN0_OUTPUT_A_O(outs[0]), .GEN0_OUTPUT_B_O(outs[1]),
        .GEN1_OUTPUT_A_O(outs[2]), .GEN1_OUTPUT_B_O(outs[3]));

    pwm_event_source pwm_event_source_i (
        .clk_i(clk), .req_i(req), .gen_i(gen), .ev_i(ev), .zero_o(zero),
        .load_o(load), .cmp_a_o(ca), .cmp_b_o(cb), .up_o(up));

    function automatic logic do_act(input logic cur, input logic [1:0] c);
        return c == `ACT_TOGGLE ? ~cur : c == `ACT_LOW ? 1'b0 : c == `ACT_HIGH ? 1'b1 : cur;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {20'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (!hready);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (!hready);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
        case (a)
            `OFS_MASTER_CTL: sreq |= d[1:0];
            `OFS_GEN0_CTL: ctl[0] = d[2:0];
            `OFS_GEN1_CTL: ctl[1] = d[2:0];
            default: if (a[5]) pend[{a[7], a[2]}] = d[11:0];
        endcase
    endtask

    task automatic rd(input logic [11:0] a);
        logic [31:0] e;
        e = 32'h0;
        case (a)
            `OFS_MASTER_CTL: e[1:0] = sreq;
            `OFS_OUT_STATE: e[3:0] = oe;
            `OFS_GEN0_CTL: e[2:0] = ctl[0];
            `OFS_GEN1_CTL: e[2:0] = ctl[1];
            default: if (a[5]) e[11:0] = pend[{a[7], a[2]}];
        endcase
        rd_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask

    // Model first, then one event cycle on the chosen generator
    task automatic pulse(input logic g, input logic [4:0] e);
        logic [11:0] c;
        logic upe;
        int i;
        upe = ctl[g][0] & e[4];
        for (i = 2 * g; i < 2 * g + 2; i++) begin
            if (e[0] && (!ctl[g][1 + i % 2] || sreq[g])) act[i] = pend[i];
            c = act[i];
            if (e[0] | e[1]) begin
                if (e[0]) oe[i] = do_act(oe[i], c[1:0]);
                if (e[1]) oe[i] = do_act(oe[i], c[3:2]);
            end else if (e[2] && !(i % 2 && e[3])) oe[i] = do_act(oe[i], upe ? c[5:4] : c[7:6]);
            else if (e[3]) oe[i] = do_act(oe[i], upe ? c[9:8] : c[11:10]);
        end
        if (e[0]) sreq[g] = 1'b0;
        if (|e[3:0]) out_q.push_back(oe);
        @(posedge clk);
        req <= 1'b1;
        gen <= g;
        ev <= e;
        @(posedge clk);
        req <= 1'b0;
    endtask

    always @(posedge clk) begin
        if (dp_rd && hready) check("read data", hrdata, rd_q.pop_front());
        if (hready) dp_rd <= hsel & htrans[1] & ~hwrite;
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
        if (|(zero | load | ca | cb)) begin
            @(negedge clk);
            e_out = out_q.pop_front();
            check("a outputs", 32'({outs[2], outs[0]}), 32'({e_out[2], e_out[0]}));
            check("b outputs", 32'({outs[3], outs[1]}), 32'({e_out[3], e_out[1]}));
        end
    end

    initial begin
        int k;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        foreach (regs[j]) rd(regs[j]);
        repeat (400) begin
            k = $unsigned($random(seed)) % 8;
            if (k < 2) wr(regs[$unsigned($random(seed)) % 9], $random(seed));
            else if (k == 2) rd(regs[$unsigned($random(seed)) % 9]);
            else pulse(1'($random(seed)), 5'($random(seed)));
        end
        foreach (regs[j]) rd(regs[j]);
        repeat (4) @(posedge clk);
        stop_test();
    end
endmodule
`default_nettype wire
